// ---- rtl/rtct_pkg.sv ----
// constants, field layouts and carrier types of the trim, backup and
// time-stamp block; assumes a 40 MHz ref_clk and a 32.768 kHz crystal
// Summary of operation
// RQ1 - coarse trim enable applies trim corrections at 128 Hz, not per minute
// RQ2 - coarse mode with square wave enable drives a trimmed 64 Hz pin clock
// RQ3 - no coarse 64 Hz square wave while running on backup supply
// RQ4 - software should not leave coarse trim on during normal timekeeping
// RQ5 - switch to backup below threshold, back to main above it, automatically
// RQ6 - backup input works only while the host has set backup input enable
// RQ7 - timekeeping, alarms, alarm output, trim and contents survive on backup
// RQ8 - serial bus, square wave and general purpose output are off on backup
// RQ9 - capture minutes, hours, date, month at power loss and power return
// RQ10 - a power failure sets the sticky power-fail flag
// RQ11 - system supplies enabled backup and running oscillator for time-stamps
// RQ12 - time-stamps are not overwritten while the power-fail flag is set
// RQ13 - clearing the power-fail flag clears both time-stamp sets
// RQ14 - stamp minutes, hours, date at 0x18-0x1a down and 0x1c-0x1e up
// RQ15 - minutes stamp: bit 7 zero, tens in bits 6-4, ones in 3-0
// RQ16 - hours stamp bit 6 is 12-hour format; then bit 5 pm, bit 4 tens
// RQ17 - 24-hour stamp: tens in bits 5-4, ones in 3-0, bit 7 zero
// RQ18 - date stamp: bits 7-6 zero, tens in bits 5-4, ones in 3-0
// RQ19 - month stamps at 0x1b/0x1f: weekday 7-5, tens bit 4, ones 3-0
// RQ20 - each trim step adds or removes two oscillator pulses; zero disables
// RQ21 - trim direction bit selects adding cycles or removing cycles
// RQ22 - stamps copy the live counters unchanged, hour format and pm included
// RQ23 - down stamp at switch to backup, up stamp at return, once per event
package rtct_pkg;

  localparam int OSC_HZ = 32768;
  localparam int COARSE_HZ = 128;
  localparam int COARSE_SQW_HZ = 64;
  localparam int COARSE_DIV = OSC_HZ / COARSE_HZ;
  localparam int COARSE_BITS = $clog2(COARSE_DIV);
  localparam int SQW_BIT = $clog2(OSC_HZ / COARSE_SQW_HZ) - 1;
  localparam int DIV_BITS = $clog2(OSC_HZ);
  localparam logic [5:0] SEC_LAST = 6'h3b;

  localparam logic [6:0] DEV_ADDR = 7'h6f;
  localparam logic [7:0] REG_SPAN = 8'h20;

  localparam logic [4:0] OFS_WEEKDAY_VALUE = 5'h03;
  localparam logic [4:0] OFS_CONTROL = 5'h07;
  localparam logic [4:0] OFS_OSCILLATOR_TRIM_SETTING = 5'h08;
  localparam logic [4:0] OFS_DOWN_MIN = 5'h18;
  localparam logic [4:0] OFS_DOWN_HOUR = 5'h19;
  localparam logic [4:0] OFS_DOWN_DATE = 5'h1a;
  localparam logic [4:0] OFS_DOWN_MTH = 5'h1b;
  localparam logic [4:0] OFS_UP_MIN = 5'h1c;
  localparam logic [4:0] OFS_UP_HOUR = 5'h1d;
  localparam logic [4:0] OFS_UP_DATE = 5'h1e;
  localparam logic [4:0] OFS_UP_MTH = 5'h1f;
  localparam logic [1:0] STAMP_PAGE = 2'h3;

  localparam int CTL_OUT = 7;
  localparam int CTL_SQUARE_WAVE_ENABLE = 6;
  localparam int CTL_ALM1EN = 5;
  localparam int CTL_ALM0EN = 4;
  localparam int CTL_COARSE = 2;
  localparam int TRIM_SIGN = 7;
  localparam int WK_OSCRUN = 5;
  localparam int WK_POWER_FAIL_FLAG = 4;
  localparam int WK_BACKUP_INPUT_ENABLE = 3;

  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h7f;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MTH = 8'hff;
  localparam logic [4:0] MASK_MONTH = 5'h1f;

  localparam logic [7:0] CONTROL_RST = 8'h80;
  localparam logic [7:0] OSCILLATOR_TRIM_SETTING_RST = 8'h00;
  localparam logic [7:0] STAMP_RST = 8'h00;

  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] date;
    logic [7:0] month;
    logic [2:0] weekday;
  } rtct_time_t;

  typedef struct packed {
    logic stb;
    logic [4:0] addr;
    logic [7:0] data;
  } rtct_wr_t;

  typedef enum logic [3:0] {
    I_IDLE, I_DEV, I_DEV_ACK, I_PTR, I_PTR_ACK, I_WR, I_WR_ACK, I_RD,
    I_RD_ACK
  } rtct_i2c_st_t;

  typedef struct packed {
    logic [2:0] scl_p;
    logic [2:0] sda_p;
    rtct_i2c_st_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic [4:0] ptr;
    logic sda_oe;
    rtct_wr_t wr;
  } rtct_i2c_state_t;

  typedef struct packed {
    logic [2:0] osc_p;
    logic [1:0] vcc_p;
    logic backup;
    logic pwr_fail;
    logic arm_up;
    logic vbat_en;
    logic [7:0] ctrl;
    logic [7:0] trim;
    logic [7:0][7:0] stamp;
    logic [DIV_BITS-1:0] div;
    logic [5:0] secs;
    logic [7:0] pend;
    logic pend_add;
    logic sec_tick;
    logic mfp_oe;
  } rtct_state_t;

endpackage

// ---- rtl/rtct_i2c_slave.sv ----
// two-wire serial slave giving byte access to registers 0x00-0x1f
// assumes scl and sda arrive from pins; held idle while bus_en is low
`timescale 1ns/1ps
module rtct_i2c_slave import rtct_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic bus_en,
  input wire logic [7:0] rd_data,
  output logic sda_oe,
  output logic [4:0] ptr,
  output rtct_wr_t wr
);

  rtct_i2c_state_t s_r;
  rtct_i2c_state_t s_nxt;
  logic scl_hold;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr.stb = 1'b0;
    s_nxt.scl_p = {s_r.scl_p[1:0], scl_pin};
    s_nxt.sda_p = {s_r.sda_p[1:0], sda_pin};
    scl_hold = s_r.scl_p[1] & s_r.scl_p[2];
    scl_rise = s_r.scl_p[1] & ~s_r.scl_p[2];
    scl_fall = ~s_r.scl_p[1] & s_r.scl_p[2];
    sda_rise = s_r.sda_p[1] & ~s_r.sda_p[2];
    sda_fall = ~s_r.sda_p[1] & s_r.sda_p[2];
    if (!bus_en) begin
      s_nxt.st = I_IDLE; // [RQ8]
      s_nxt.sda_oe = 1'b0;
    end else if (scl_hold && sda_fall) begin
      s_nxt.st = I_DEV;
      s_nxt.bits = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (scl_hold && sda_rise) begin
      s_nxt.st = I_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (s_r.st)
        I_DEV, I_PTR, I_WR: begin
          s_nxt.sh = {s_r.sh[6:0], s_r.sda_p[1]};
          s_nxt.bits = s_r.bits + 4'h1;
        end
        I_RD_ACK: begin
          if (s_r.sda_p[1]) begin
            s_nxt.st = I_IDLE;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (s_r.st)
        I_DEV: begin
          if (s_r.bits == 4'h8) begin
            if (s_r.sh[7:1] == DEV_ADDR) begin
              s_nxt.rw = s_r.sh[0];
              s_nxt.st = I_DEV_ACK;
              s_nxt.sda_oe = 1'b1;
              s_nxt.bits = 4'h0;
            end else begin
              s_nxt.st = I_IDLE;
            end
          end
        end
        I_PTR: begin
          if (s_r.bits == 4'h8) begin
            if (s_r.sh < REG_SPAN) begin
              s_nxt.ptr = s_r.sh[4:0];
              s_nxt.st = I_PTR_ACK;
              s_nxt.sda_oe = 1'b1;
              s_nxt.bits = 4'h0;
            end else begin
              s_nxt.st = I_IDLE;
            end
          end
        end
        I_WR: begin
          if (s_r.bits == 4'h8) begin
            s_nxt.wr.stb = 1'b1;
            s_nxt.wr.addr = s_r.ptr;
            s_nxt.wr.data = s_r.sh;
            s_nxt.st = I_WR_ACK;
            s_nxt.sda_oe = 1'b1;
            s_nxt.bits = 4'h0;
          end
        end
        I_DEV_ACK: begin
          if (s_r.rw) begin
            s_nxt.st = I_RD;
            s_nxt.sh = rd_data;
            s_nxt.sda_oe = ~rd_data[7];
            s_nxt.bits = 4'h1;
          end else begin
            s_nxt.st = I_PTR;
            s_nxt.sda_oe = 1'b0;
          end
        end
        I_PTR_ACK: begin
          s_nxt.st = I_WR;
          s_nxt.sda_oe = 1'b0;
        end
        I_WR_ACK: begin
          s_nxt.ptr = s_r.ptr + 5'h01;
          s_nxt.st = I_WR;
          s_nxt.sda_oe = 1'b0;
        end
        I_RD: begin
          if (s_r.bits == 4'h8) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = I_RD_ACK;
            s_nxt.ptr = s_r.ptr + 5'h01;
            s_nxt.bits = 4'h0;
          end else begin
            s_nxt.sh = {s_r.sh[6:0], 1'b0};
            s_nxt.sda_oe = ~s_r.sh[6];
            s_nxt.bits = s_r.bits + 4'h1;
          end
        end
        I_RD_ACK: begin
          s_nxt.st = I_RD;
          s_nxt.sh = rd_data;
          s_nxt.sda_oe = ~rd_data[7];
          s_nxt.bits = 4'h1;
        end
        default: s_nxt.st = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.scl_p <= 3'h7;
      s_r.sda_p <= 3'h7;
      s_r.st <= I_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_oe = s_r.sda_oe;
  assign ptr = s_r.ptr;
  assign wr = s_r.wr;

endmodule

// ---- rtl/rtct_top.sv ----
// coarse trim, supply switchover and power-fail time-stamp logic
// assumes live time counters and alarm level come from ref_clk logic;
// oscillator, supply comparator and bus pins are asynchronous
`timescale 1ns/1ps
module rtct_top import rtct_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic osc_clk_pin,
  input wire logic main_ok_pin,
  input wire logic i2c_scl_pin,
  input wire logic i2c_sda_pin,
  output logic i2c_sda_o,
  output logic i2c_sda_oe,
  output logic multi_function_pin_o,
  output logic multi_function_pin_oe,
  input rtct_time_t time_now,
  input wire logic alarm_level,
  input wire logic osc_running,
  output logic sec_tick,
  output logic backup_active,
  output logic [7:0] control_bits,
  output rtct_wr_t host_wr
);

  rtct_state_t s_r;
  rtct_state_t s_nxt;
  rtct_wr_t wr;
  logic [4:0] ptr;
  logic [7:0] rd_data;
  logic bus_oe;
  logic osc_tick;
  logic down_evt;
  logic up_evt;
  logic pf_clr;
  logic pf_held;
  logic trim_evt;
  logic coarse_evt;
  logic alm_en;
  logic freq_bit;
  logic pin_level;
  logic [1:0] inc;
  logic [DIV_BITS:0] sum;
  logic [COARSE_BITS:0] lo;

  // stamp bytes in the same bcd layout as the live counters
  function automatic logic [3:0][7:0] capture(input rtct_time_t t);
    logic [3:0][7:0] c;
    c[3] = {t.weekday, t.month[4:0] & MASK_MONTH}; // [RQ19]
    c[2] = t.date & MASK_DATE; // [RQ18]
    c[1] = t.hours & MASK_HOUR; // [RQ16] [RQ17]
    c[0] = t.minutes & MASK_MIN; // [RQ15]
    return c; // [RQ22]
  endfunction

  function automatic logic [7:0] stamp_mask(input logic [1:0] idx);
    logic [7:0] m;
    case (idx)
      2'h0: m = MASK_MIN;
      2'h1: m = MASK_HOUR;
      2'h2: m = MASK_DATE;
      default: m = MASK_MTH;
    endcase
    return m;
  endfunction

  rtct_i2c_slave u_bus (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .scl_pin(i2c_scl_pin),
    .sda_pin(i2c_sda_pin),
    .bus_en(~s_r.backup), // [RQ8]
    .rd_data(rd_data),
    .sda_oe(bus_oe),
    .ptr(ptr),
    .wr(wr)
  );

  // register read view at the bus pointer
  always_comb begin
    rd_data = 8'h00;
    case (ptr)
      OFS_WEEKDAY_VALUE: begin
        rd_data[WK_OSCRUN] = osc_running;
        rd_data[WK_POWER_FAIL_FLAG] = s_r.pwr_fail;
        rd_data[WK_BACKUP_INPUT_ENABLE] = s_r.vbat_en;
        rd_data[2:0] = time_now.weekday;
      end
      OFS_CONTROL: rd_data = s_r.ctrl;
      OFS_OSCILLATOR_TRIM_SETTING: rd_data = s_r.trim;
      default: begin
        if (ptr[4:3] == STAMP_PAGE) begin
          // reserved stamp bits read as zero
          rd_data = s_r.stamp[ptr[2:0]] & stamp_mask(ptr[1:0]); // [RQ14]
        end
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.osc_p = {s_r.osc_p[1:0], osc_clk_pin};
    s_nxt.vcc_p = {s_r.vcc_p[0], main_ok_pin};
    osc_tick = s_r.osc_p[1] & ~s_r.osc_p[2];

    // supply selection follows the comparator while backup is allowed
    s_nxt.backup = ~s_r.vcc_p[1] & s_r.vbat_en; // [RQ5] [RQ6]
    down_evt = s_nxt.backup & ~s_r.backup; // [RQ23]
    up_evt = ~s_nxt.backup & s_r.backup; // [RQ23]

    // divider runs on either supply; pending trim adds or swallows ticks
    inc = 2'h0;
    if (osc_tick) begin
      if (s_r.pend != 8'h00) begin
        inc = s_r.pend_add ? 2'h2 : 2'h0; // [RQ21]
        s_nxt.pend = s_r.pend - 8'h01; // [RQ7]
      end else begin
        inc = 2'h1;
      end
    end
    sum = {1'b0, s_r.div} + {{(DIV_BITS-1){1'b0}}, inc};
    lo = {1'b0, s_r.div[COARSE_BITS-1:0]} +
      {{(COARSE_BITS-1){1'b0}}, inc};
    s_nxt.div = sum[DIV_BITS-1:0];
    s_nxt.sec_tick = sum[DIV_BITS];
    coarse_evt = lo[COARSE_BITS];
    if (sum[DIV_BITS]) begin
      s_nxt.secs = (s_r.secs == SEC_LAST) ? 6'h00 : s_r.secs + 6'h01;
    end
    if (s_r.ctrl[CTL_COARSE]) begin
      trim_evt = coarse_evt; // [RQ1]
    end else begin
      trim_evt = sum[DIV_BITS] && (s_r.secs == SEC_LAST);
    end
    // two pulses per step; a zero amount leaves the divider alone
    if (trim_evt && (s_r.trim[6:0] != 7'h00)) begin
      s_nxt.pend = {s_r.trim[6:0], 1'b0}; // [RQ20]
      s_nxt.pend_add = s_r.trim[TRIM_SIGN]; // [RQ21]
    end

    // multi-function pin, open drain: enable pulls it low
    alm_en = s_r.ctrl[CTL_ALM0EN] | s_r.ctrl[CTL_ALM1EN];
    case (s_r.ctrl[1:0])
      2'h0: freq_bit = s_r.div[DIV_BITS-1];
      2'h1: freq_bit = s_r.div[2];
      2'h2: freq_bit = s_r.div[1];
      default: freq_bit = s_r.osc_p[2];
    endcase
    if (s_r.backup) begin
      // only the alarm output survives on backup
      pin_level = alm_en ? alarm_level : 1'b1; // [RQ3] [RQ7] [RQ8]
    end else if (s_r.ctrl[CTL_SQUARE_WAVE_ENABLE]) begin
      if (s_r.ctrl[CTL_COARSE]) begin
        pin_level = s_r.div[SQW_BIT]; // [RQ2]
      end else begin
        pin_level = freq_bit;
      end
    end else if (alm_en) begin
      pin_level = alarm_level;
    end else begin
      pin_level = s_r.ctrl[CTL_OUT];
    end
    s_nxt.mfp_oe = ~pin_level;

    // host writes; the bus is held off on backup
    pf_clr = 1'b0;
    if (wr.stb) begin
      case (wr.addr)
        OFS_WEEKDAY_VALUE: begin
          s_nxt.vbat_en = wr.data[WK_BACKUP_INPUT_ENABLE]; // [RQ6]
          pf_clr = ~wr.data[WK_POWER_FAIL_FLAG];
        end
        OFS_CONTROL: s_nxt.ctrl = wr.data;
        OFS_OSCILLATOR_TRIM_SETTING: s_nxt.trim = wr.data;
        default: begin
          if (wr.addr[4:3] == STAMP_PAGE) begin
            s_nxt.stamp[wr.addr[2:0]] = wr.data &
              stamp_mask(wr.addr[1:0]); // [RQ14]
          end
        end
      endcase
    end
    if (pf_clr) begin
      s_nxt.pwr_fail = 1'b0;
      s_nxt.arm_up = 1'b0;
      s_nxt.stamp = '0; // [RQ13]
    end

    // capture follows the clear so a coincident power event wins
    pf_held = s_r.pwr_fail & ~pf_clr;
    if (down_evt) begin
      if (!pf_held) begin
        s_nxt.stamp[3:0] = capture(time_now); // [RQ9] [RQ12]
        s_nxt.arm_up = 1'b1;
      end
      s_nxt.pwr_fail = 1'b1; // [RQ10]
    end
    if (up_evt && s_r.arm_up) begin
      s_nxt.stamp[7:4] = capture(time_now); // [RQ9] [RQ23]
      s_nxt.arm_up = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.vcc_p <= 2'h3;
      s_r.ctrl <= CONTROL_RST;
      s_r.trim <= OSCILLATOR_TRIM_SETTING_RST;
      s_r.stamp <= {8{STAMP_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign i2c_sda_o = 1'b0;
  assign i2c_sda_oe = bus_oe;
  assign multi_function_pin_o = 1'b0;
  assign multi_function_pin_oe = s_r.mfp_oe;
  assign sec_tick = s_r.sec_tick;
  assign backup_active = s_r.backup;
  assign control_bits = s_r.ctrl;
  assign host_wr = wr;

  // coarse square wave follows divider bit on main supply
  a_coarse_sqw_pin: assert property ( // [RQ2]
    @(posedge ref_clk) disable iff (!rstn)
    (!s_r.backup && s_r.ctrl[CTL_SQUARE_WAVE_ENABLE] && s_r.ctrl[CTL_COARSE])
    |=> (s_r.mfp_oe == !$past(s_r.div[SQW_BIT])))
    else $error("coarse square wave not on pin");

  a_backup_no_sqw: assert property ( // [RQ3]
    @(posedge ref_clk) disable iff (!rstn)
    (s_r.backup && !alm_en) |=> !s_r.mfp_oe)
    else $error("pin driven on backup without alarm");

  a_bus_off_backup: assert property ( // [RQ8]
    @(posedge ref_clk) disable iff (!rstn)
    (s_r.backup ##1 s_r.backup) |-> !i2c_sda_oe)
    else $error("bus driven on backup");

  a_backup_needs_en: assert property ( // [RQ6]
    @(posedge ref_clk) disable iff (!rstn)
    !s_r.vbat_en |=> !s_r.backup)
    else $error("backup without enable");

  a_switch_follows: assert property ( // [RQ5]
    @(posedge ref_clk) disable iff (!rstn)
    (s_r.vbat_en && !s_r.vcc_p[1]) |=> s_r.backup)
    else $error("no switch to backup");

  a_fail_flag_set: assert property ( // [RQ10]
    @(posedge ref_clk) disable iff (!rstn)
    down_evt |=> s_r.pwr_fail)
    else $error("power-fail flag not set");

  a_down_stamp: assert property ( // [RQ9]
    @(posedge ref_clk) disable iff (!rstn)
    (down_evt && !s_r.pwr_fail && !wr.stb)
    |=> (s_r.stamp[0] == ($past(time_now.minutes) & MASK_MIN)) &&
      (s_r.stamp[1] == ($past(time_now.hours) & MASK_HOUR)))
    else $error("power-down stamp wrong");

  a_up_stamp_once: assert property ( // [RQ23]
    @(posedge ref_clk) disable iff (!rstn)
    (up_evt && s_r.arm_up)
    |=> !s_r.arm_up && (s_r.stamp[6] == ($past(time_now.date) & MASK_DATE)))
    else $error("power-up stamp wrong");

  a_stamp_kept: assert property ( // [RQ12]
    @(posedge ref_clk) disable iff (!rstn)
    (down_evt && s_r.pwr_fail && !wr.stb) |=> $stable(s_r.stamp))
    else $error("stamps overwritten while flag set");

  a_stamp_clear: assert property ( // [RQ13]
    @(posedge ref_clk) disable iff (!rstn)
    (pf_clr && !down_evt && !up_evt)
    |=> (s_r.stamp == '0) && !s_r.pwr_fail)
    else $error("stamps not cleared with flag");

  a_trim_load: assert property ( // [RQ20]
    @(posedge ref_clk) disable iff (!rstn)
    (trim_evt && s_r.trim[6:0] != 7'h00)
    |=> (s_r.pend == {$past(s_r.trim[6:0]), 1'b0}))
    else $error("trim amount not loaded");

  a_coarse_rate: assert property ( // [RQ1]
    @(posedge ref_clk) disable iff (!rstn)
    (s_r.ctrl[CTL_COARSE] && coarse_evt && s_r.trim[6:0] != 7'h00)
    |=> (s_r.pend != 8'h00))
    else $error("coarse trim event missed");

  a_min_bit7: assert property ( // [RQ15]
    @(posedge ref_clk) disable iff (!rstn)
    (ptr == OFS_DOWN_MIN || ptr == OFS_UP_MIN) |-> !rd_data[7])
    else $error("minutes stamp bit 7 set");

endmodule

// ---- verif/rtct_host.sv ----
// two-wire bus master standing in for the host controller
// assumes the bench resolves sda from both open-drain enables
`timescale 1ns/1ps
module rtct_host import rtct_pkg::*; (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_oe
);
  localparam int Q = 4;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic qw(input int n);
    repeat (n * Q) @(posedge ref_clk);
  endtask
  // serves as start and repeated start
  task automatic start();
    sda_oe <= 1'b0;
    qw(1);
    scl <= 1'b1;
    qw(1);
    sda_oe <= 1'b1;
    qw(1);
    scl <= 1'b0;
    qw(1);
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    qw(1);
    scl <= 1'b1;
    qw(1);
    sda_oe <= 1'b0;
    qw(2);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe <= !b[i];
      qw(1);
      scl <= 1'b1;
      qw(2);
      scl <= 1'b0;
      qw(1);
    end
    sda_oe <= 1'b0;
    qw(1);
    scl <= 1'b1;
    qw(1);
    ack = !sda_line;
    qw(1);
    scl <= 1'b0;
    qw(1);
  endtask
  task automatic get(input logic more, output logic [7:0] b);
    sda_oe <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      qw(1);
      scl <= 1'b1;
      qw(1);
      b[i] = sda_line;
      qw(1);
      scl <= 1'b0;
    end
    qw(1);
    sda_oe <= more;
    qw(1);
    scl <= 1'b1;
    qw(2);
    scl <= 1'b0;
    qw(1);
  endtask
  task automatic wr_reg(input logic [7:0] a, d, output logic ok);
    logic k;
    start();
    put({DEV_ADDR, 1'b0}, k);
    ok = k;
    put(a, k);
    ok &= k;
    put(d, k);
    ok &= k;
    stop();
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    put({DEV_ADDR, 1'b0}, k);
    put(a, k);
    start();
    put({DEV_ADDR, 1'b1}, k);
    get(1'b0, d);
    stop();
  endtask
endmodule

// ---- verif/testbench.sv ----
// register-level tests of trim, switchover and time-stamp logic
// assumes rtct_host as bus master; oscillator ticks every 8 ref_clk
`timescale 1ns/1ps
module testbench import rtct_pkg::*;;
  localparam rtct_time_t TA = '{8'h59, 8'h71, 8'h31, 8'h12, 3'h5};
  localparam rtct_time_t TB = '{8'h05, 8'h23, 8'h01, 8'h09, 3'h2};
  localparam rtct_time_t TC = '{8'h30, 8'h10, 8'h15, 8'h06, 3'h1};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic osc_clk_pin = 1'b0;
  logic [2:0] osc_div = 3'h0;
  logic main_ok_pin = 1'b1;
  logic scl, host_oe, sda_o, sda_oe, mfp_o, mfp_oe, sec_tick, backup_active;
  logic alarm_level = 1'b0;
  logic osc_running = 1'b1;
  rtct_time_t time_now = '0;
  logic [7:0] control_bits;
  rtct_wr_t host_wr, last_wr;
  wire sda_line = !(host_oe | sda_oe);
  int mismatches = 0;
  int comparisons = 0;
  int n;
  int secs_seen = 0;
  logic [7:0] mk [4] = '{MASK_MIN, MASK_HOUR, MASK_DATE, MASK_MTH};
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    osc_div <= osc_div + 3'h1;
    osc_clk_pin <= osc_div[2];
    if (host_wr.stb === 1'b1) last_wr <= host_wr;
    if (sec_tick === 1'b1) secs_seen <= secs_seen + 1;
  end
  rtct_host host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
    .sda_oe(host_oe));
  rtct_top dut (.ref_clk(ref_clk), .rstn(rstn), .osc_clk_pin(osc_clk_pin),
    .main_ok_pin(main_ok_pin), .i2c_scl_pin(scl), .i2c_sda_pin(sda_line),
    .i2c_sda_o(sda_o), .i2c_sda_oe(sda_oe), .multi_function_pin_o(mfp_o),
    .multi_function_pin_oe(mfp_oe), .time_now(time_now),
    .alarm_level(alarm_level), .osc_running(osc_running),
    .sec_tick(sec_tick), .backup_active(backup_active),
    .control_bits(control_bits), .host_wr(host_wr));
  task automatic test_done();
    $display("counts: %0d mismatches, %0d comparisons", mismatches,
      comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check1(input logic seen, exp);
    check({7'h0, seen}, {7'h0, exp});
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    logic [7:0] d;
    host.rd_reg(a, d);
    check(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, d, input logic exp_ack);
    logic ok;
    host.wr_reg(a, d, ok);
    check1(ok, exp_ack);
  endtask
  function automatic logic [31:0] stamp_of(input rtct_time_t t);
    return {t.minutes, t.hours, t.date, t.weekday, t.month[4:0]};
  endfunction
  task automatic chk_stamps(input logic [31:0] dn, up);
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'h18 + 8'(i), dn[31 - 8 * i -: 8]);
      rd_chk(8'h1c + 8'(i), up[31 - 8 * i -: 8]);
    end
  endtask
  // main supply drops and returns; bus must be refused while on backup
  task automatic dip(input rtct_time_t a, b, input logic exp_bk);
    time_now <= a;
    tick(5);
    main_ok_pin <= 1'b0;
    tick(10);
    check1(backup_active, exp_bk);
    wr(8'h08, 8'h00, !exp_bk);
    time_now <= b;
    main_ok_pin <= 1'b1;
    tick(10);
    check1(backup_active, 1'b0);
  endtask
  task automatic wait_oe(input logic v, inout int k);
    while (mfp_oe !== v && k < 10000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
  endtask
  // full pin period between two rising pin levels, in ref_clk cycles
  task automatic measure(output int c);
    int k;
    k = 0;
    wait_oe(1'b1, k);
    wait_oe(1'b0, k);
    k = 0;
    wait_oe(1'b1, k);
    wait_oe(1'b0, k);
    c = k;
  endtask
  initial begin
    tick(95000);
    mismatches++;
    test_done();
  end
  initial begin
    tick(20);
    rstn <= 1'b1;
    tick(6);
    check(control_bits, CONTROL_RST);
    rd_chk(8'h07, CONTROL_RST);
    rd_chk(8'h08, OSCILLATOR_TRIM_SETTING_RST);
    for (int i = 0; i < 8; i++) rd_chk(8'h18 + 8'(i), STAMP_RST);
    wr(8'h03, 8'h08, 1'b1);
    check({3'h0, last_wr.addr}, {3'h0, OFS_WEEKDAY_VALUE});
    check(last_wr.data, 8'h08);
    for (int i = 0; i < 8; i++) begin
      wr(8'h18 + 8'(i), 8'hff, 1'b1);
      rd_chk(8'h18 + 8'(i), mk[i % 4]);
    end
    wr(8'h20, 8'h00, 1'b0);
    dip(TA, TB, 1'b1);
    chk_stamps(stamp_of(TA), stamp_of(TB));
    rd_chk(8'h03, 8'h3a);
    dip(TC, TA, 1'b1);
    chk_stamps(stamp_of(TA), stamp_of(TB));
    wr(8'h03, 8'h08, 1'b1);
    chk_stamps(32'h0, 32'h0);
    rd_chk(8'h03, 8'h2d);
    wr(8'h03, 8'h00, 1'b1);
    dip(TC, TC, 1'b0);
    rd_chk(8'h03, 8'h21);
    wr(8'h03, 8'h08, 1'b1);
    wr(8'h07, 8'h44, 1'b1);
    measure(n);
    check1(n >= 4088 && n <= 4104, 1'b1);
    wr(8'h08, 8'h85, 1'b1);
    measure(n);
    measure(n);
    check1(n >= 3900 && n <= 3970, 1'b1);
    wr(8'h08, 8'h05, 1'b1);
    measure(n);
    measure(n);
    check1(n >= 4230 && n <= 4300, 1'b1);
    main_ok_pin <= 1'b0;
    tick(10);
    n = 0;
    repeat (2000) begin
      @(posedge ref_clk);
      #1;
      if (mfp_oe !== 1'b0) n++;
    end
    check1(n == 0, 1'b1);
    check(control_bits, 8'h44);
    main_ok_pin <= 1'b1;
    tick(10);
    wr(8'h07, 8'h80, 1'b1);
    tick(4);
    check1(mfp_oe, 1'b0);
    // alarm keeps the pin on backup, general purpose output does not
    wr(8'h07, 8'h10, 1'b1);
    tick(4);
    check1(mfp_oe, 1'b1);
    main_ok_pin <= 1'b0;
    tick(10);
    check1(mfp_oe, 1'b1);
    alarm_level <= 1'b1;
    tick(4);
    check1(mfp_oe, 1'b0);
    alarm_level <= 1'b0;
    main_ok_pin <= 1'b1;
    tick(10);
    wr(8'h07, 8'h00, 1'b1);
    tick(4);
    check1(mfp_oe, 1'b1);
    main_ok_pin <= 1'b0;
    tick(10);
    check1(mfp_oe, 1'b0);
    main_ok_pin <= 1'b1;
    tick(10);
    // 4096 Hz selection: eight divider counts of eight cycles each
    wr(8'h07, 8'h41, 1'b1);
    measure(n);
    check1(n == 64, 1'b1);
    // far fewer than one second of ticks elapse in this run
    check(8'(secs_seen), 8'h00);
    check1(sda_o | mfp_o, 1'b0);
    test_done();
  end
endmodule
